// ==== core/alu_slice_array.sv ====
// four 4-bit alu slices with two-port register file and look-ahead carry
`timescale 1ns/1ps
module alu_slice_array (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic [3:0] addr_a,
  input wire logic [3:0] addr_b,
  input wire logic [2:0] src_sel,
  input wire logic [2:0] fn_sel,
  input wire logic [2:0] dst_sel,
  input wire logic [15:0] d_in,
  input wire logic carry_in,
  output logic [15:0] y_out,
  output logic carry_out
);
  logic [15:0] regs [16];
  logic [15:0] q_q;
  logic [15:0] r_op, s_op, rr, f;
  logic [4:0] c;
  logic [3:0] g, p;
  wire [15:0] a_val = regs[addr_a];
  wire [15:0] b_val = regs[addr_b];
  function automatic logic [1:0] slice_gp(input logic [3:0] x, input logic [3:0] y);
    logic [3:0] gg, pp;
    gg = x & y;
    pp = x | y;
    slice_gp = {pp[3] & pp[2] & pp[1] & pp[0],
                gg[3] | (pp[3] & gg[2]) | (pp[3] & pp[2] & gg[1]) | (pp[3] & pp[2] & pp[1] & gg[0])};
  endfunction : slice_gp
  always_comb begin
    unique case (src_sel)
      3'h0: begin r_op = a_val; s_op = q_q; end
      3'h1: begin r_op = a_val; s_op = b_val; end
      3'h2: begin r_op = 16'h0000; s_op = q_q; end
      3'h3: begin r_op = 16'h0000; s_op = b_val; end
      3'h4: begin r_op = 16'h0000; s_op = a_val; end
      3'h5: begin r_op = d_in; s_op = a_val; end
      3'h6: begin r_op = d_in; s_op = q_q; end
      3'h7: begin r_op = d_in; s_op = 16'h0000; end
    endcase
  end
  // subtraction folds into add by inverting one operand
  assign rr = (fn_sel == 3'h1) ? ~r_op : r_op;
  wire [15:0] ss = (fn_sel == 3'h2) ? ~s_op : s_op;
  // group carries c[1]-c[3] are formed in parallel; c[4] is rippled from c[3]
  always_comb begin
    c[0] = carry_in;
    for (int i = 0; i < 4; i++) begin
      {p[i], g[i]} = slice_gp(rr[i*4 +: 4], ss[i*4 +: 4]);
    end
    c[1] = g[0] | (p[0] & c[0]);
    c[2] = g[1] | (p[1] & g[0]) | (p[1] & p[0] & c[0]);
    c[3] = g[2] | (p[2] & g[1]) | (p[2] & p[1] & g[0]) | (p[2] & p[1] & p[0] & c[0]);
    c[4] = g[3] | (p[3] & c[3]);
  end
  logic [15:0] carries;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      carries[k*4] = c[k];
      for (int j = 1; j < 4; j++) begin
        carries[k*4+j] = (rr[k*4+j-1] & ss[k*4+j-1]) | ((rr[k*4+j-1] ^ ss[k*4+j-1]) & carries[k*4+j-1]);
      end
    end
  end
  always_comb begin
    unique case (fn_sel)
      3'h0, 3'h1, 3'h2: f = rr ^ ss ^ carries;
      3'h3: f = r_op | s_op;
      3'h4: f = r_op & s_op;
      3'h5: f = ~r_op & s_op;
      3'h6: f = r_op ^ s_op;
      3'h7: f = ~(r_op ^ s_op);
    endcase
  end
  assign carry_out = c[4];
  assign y_out = (dst_sel == 3'h2) ? a_val : f;
  wire [15:0] b_next = dst_sel[2] ? (dst_sel[1] ? {f[14:0], 1'b0} : {1'b0, f[15:1]}) : f;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q_q <= 16'h0000;
    end else if (tick && (dst_sel == 3'h0)) begin
      q_q <= f;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (tick && dst_sel >= 3'h2) begin
      regs[addr_b] <= b_next;
    end
  end
endmodule : alu_slice_array

// ==== core/microengine_field_decode_datapath.sv ====
// microword field decode and 16-bit execution datapath of the i/o microengine
// Summary of operation
// RULE1 - literal flip-flops load word bits 32-47 always
// RULE2 - literal enable drives literal onto alu input
// RULE3 - eight-bit literal from nibbles 36-39, 40-43
// RULE4 - address counter steps one on up/down order
// RULE5 - load signal loads counter from internal bus
// RULE6 - twelve-bit counter; low eight address control store
// RULE7 - scratch address muxed: counter or word bits 36-47
// RULE8 - scratch pad written/read only when decoded
// RULE9 - scratch read straight or bytes exchanged
// RULE10 - alu source, function, destination from word fields
// RULE11 - register file ports addressed by bits 4-11
// RULE12 - look-ahead carry across four slices
// RULE13 - stack counter cleared by order and reset
// RULE14 - three enabled test banks ored for branch
// RULE15 - mini test field picks test 0 or 16
// RULE16 - bit 31 inverts selected test result
// RULE17 - format six always branches; seven increments
// RULE18 - long pulse format: decode shared by groups
// RULE19 - pulse orders low from mid to end
// RULE20 - short pulse format fires group a only
// RULE21 - level format: bit 36 value, 37-43 index
// RULE22 - level latches reset low, update mid-cycle
// RULE23 - tests at fetch, execution from word register
// RULE24 - one bus source, destination captured at end
`timescale 1ns/1ps
module microengine_field_decode_datapath #(
  parameter int LEVEL_ORDERS = 128,
  parameter int STACK_DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [47:0] control_store,
  input wire logic [31:0] test_bank_a,
  input wire logic [31:0] test_bank_b,
  input wire logic [31:0] test_bank_c,
  input wire logic [15:0] ext_bus_in,
  output logic branch_take,
  output logic phase_three_clock,
  output logic [7:0] wcs_addr,
  output logic [15:0] internal_data_bus,
  output logic [15:0] ext_bus_out,
  output logic ext_bus_strobe,
  output logic [15:0] stack_top,
  output logic [3:0] stack_ptr,
  output logic [LEVEL_ORDERS-1:0] level_orders,
  output microengine_pkg::pulse_orders_s pulse_orders_n
);
  import microengine_pkg::*;
  initial begin
    if (LEVEL_ORDERS != 128 || STACK_DEPTH != 16) $error("level/stack sizes are fixed by the word fields");
  end
  // ----------------------------------------------------------------
  // microcycle timing
  // ----------------------------------------------------------------
  logic [4:0] phase_q;
  wire micro_end = (phase_q == PH_LAST);
  wire micro_mid = (phase_q == PH_MID - 5'h01);
  wire pulse_window = (phase_q >= PH_MID);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= 5'h00;
    end else begin
      phase_q <= micro_end ? 5'h00 : phase_q + 5'h01;
    end
  end
  assign phase_three_clock = micro_end;
  // ----------------------------------------------------------------
  // pipeline: fetch-stage tests, register-stage execution
  // ----------------------------------------------------------------
  logic [47:0] control_word_register_q;
  logic [15:0] literal_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      control_word_register_q <= {3{RESET_WORD}};
      literal_q <= RESET_WORD;
    end else if (micro_end) begin
      control_word_register_q <= control_store; // [RULE23]
      literal_q <= control_store[LIT_LSB +: 16]; // [RULE1]
    end
  end
  wire [47:0] cw = control_word_register_q;
  // ----------------------------------------------------------------
  // test selection and summation (fetch stage)
  // ----------------------------------------------------------------
  wire format_e fetch_fmt = format_e'(control_store[FMT_LSB +: 3]);
  wire [2:0] bank_en = control_store[TEST_EN_LSB +: 3];
  wire polarity = control_store[POLARITY_BIT];
  wire [4:0] full_idx = {control_store[TIDX_MSB_BIT], control_store[TEST_IDX_LSB +: 4]};
  wire [4:0] mini_idx = {control_store[TEST_IDX_LSB], 4'h0}; // [RULE15]
  wire is_mini = (fetch_fmt == FMT_LEVEL) || (fetch_fmt == FMT_MINI2) || (fetch_fmt == FMT_MINI3);
  wire is_full = (fetch_fmt == FMT_FULL0) || (fetch_fmt == FMT_FULL4);
  wire [4:0] tidx = is_mini ? mini_idx : full_idx;
  wire [2:0] hit = {test_bank_c[tidx], test_bank_b[tidx], test_bank_a[tidx]};
  wire [2:0] hit_pol = hit ^ {3{polarity}}; // [RULE16]
  wire tests_on = is_full || is_mini;
  wire test_sum = tests_on && |(hit_pol & bank_en); // [RULE14]
  assign branch_take = (fetch_fmt == FMT_JUMP) || test_sum; // [RULE17]
  // ----------------------------------------------------------------
  // register-stage field decode
  // ----------------------------------------------------------------
  wire format_e exec_fmt = format_e'(cw[FMT_LSB +: 3]);
  wire bus_src_e src = bus_src_e'(cw[BUS_SRC_LSB +: 3]);
  wire bus_dst_e dst = bus_dst_e'(cw[BUS_DST_LSB +: 3]);
  wire literal_drive_enable = (src == SRC_LIT16);
  wire [7:0] literal8 = {literal_q[LIT8_HI_LSB-LIT_LSB +: 4], literal_q[LIT8_LO_LSB-LIT_LSB +: 4]}; // [RULE3]
  logic [15:0] alu_input_bus;
  always_comb begin
    unique case (1'b1)
      literal_drive_enable: alu_input_bus = literal_q; // [RULE2]
      src == SRC_LIT8: alu_input_bus = {8'h00, literal8};
      default: alu_input_bus = ext_bus_in;
    endcase
  end
  // ----------------------------------------------------------------
  // alu
  // ----------------------------------------------------------------
  logic [15:0] alu_y;
  alu_slice_array u_alu (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tick(micro_end),
    .addr_a(cw[ALU_A_LSB +: 4]), // [RULE11]
    .addr_b(cw[ALU_B_LSB +: 4]),
    .src_sel(cw[ALU_SRC_LSB +: 3]), // [RULE10]
    .fn_sel(cw[ALU_FN_LSB +: 3]),
    .dst_sel(cw[ALU_DST_LSB +: 3]),
    .d_in(alu_input_bus),
    .carry_in(cw[CARRY_BIT]), // [RULE12]
    .y_out(alu_y),
    .carry_out()
  );
  // ----------------------------------------------------------------
  // pulse orders
  // ----------------------------------------------------------------
  wire [15:0] po_onehot = 16'h0001 << cw[PO_DEC_LSB +: 4];
  wire long_po = (exec_fmt == FMT_MINI2);
  wire short_po = (exec_fmt == FMT_FULL0);
  wire [3:0] grp_en = long_po ? cw[GRP_EN_LSB +: 4] : {3'b000, short_po}; // [RULE18] [RULE20]
  logic [63:0] po_active;
  always_comb begin
    for (int gidx = 0; gidx < 4; gidx++) begin
      po_active[gidx*16 +: 16] = grp_en[gidx] ? po_onehot : 16'h0000;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pulse_orders_n <= '1;
    end else begin
      // low from the middle through the end of the microcycle
      pulse_orders_n <= ~((pulse_window && !micro_end) || micro_mid ? po_active : 64'h0); // [RULE19]
    end
  end
  wire order_up = po_active[PO_COUNT_UP];
  wire order_down = po_active[PO_COUNT_DOWN];
  wire order_stack_reset = po_active[PO_STACK_RESET];
  wire scratch_addr_count_up_order = order_up;
  wire scratch_addr_count_down_order = order_down;
  // ----------------------------------------------------------------
  // scratch pad and address counter
  // ----------------------------------------------------------------
  logic [11:0] ram_address_counter_q;
  wire scratch_addr_load = (dst == DST_ADDR);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ram_address_counter_q <= 12'h000;
    end else if (micro_end) begin
      if (scratch_addr_load) begin
        ram_address_counter_q <= internal_data_bus[11:0]; // [RULE5]
      end else if (scratch_addr_count_up_order) begin
        ram_address_counter_q <= ram_address_counter_q + 12'h001; // [RULE4]
      end else if (scratch_addr_count_down_order) begin
        ram_address_counter_q <= ram_address_counter_q - 12'h001;
      end
    end
  end
  assign wcs_addr = ram_address_counter_q[7:0]; // [RULE6]
  wire [11:0] scratch_addr = cw[ADDR_SEL_BIT] ? cw[SP_DIRECT_LSB +: 12] : ram_address_counter_q; // [RULE7]
  wire scratch_we = micro_end && (dst == DST_SCRATCH); // [RULE8]
  logic [15:0] scratch_ram_out;
  scratch_pad_ram #(
    .ADDR_W(12),
    .DATA_W(16)
  ) u_scratch (
    .clk_sys(clk_sys),
    .addr(scratch_addr),
    .wdata(internal_data_bus),
    .we(scratch_we),
    .swap(cw[SWAP_BIT]), // [RULE9]
    .rdata(scratch_ram_out)
  );
  // ----------------------------------------------------------------
  // jump stack
  // ----------------------------------------------------------------
  logic [15:0] jump_stack [STACK_DEPTH];
  logic [3:0] stack_ptr_q;
  wire stack_push = micro_end && (dst == DST_STACK);
  wire stack_pop = micro_end && (src == SRC_STACK);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stack_ptr_q <= 4'h0; // [RULE13]
    end else if (micro_end && order_stack_reset) begin
      stack_ptr_q <= 4'h0; // [RULE13]
    end else if (stack_push) begin
      stack_ptr_q <= stack_ptr_q + 4'h1;
    end else if (stack_pop) begin
      stack_ptr_q <= stack_ptr_q - 4'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (stack_push) begin
      jump_stack[stack_ptr_q] <= internal_data_bus;
    end
  end
  assign stack_ptr = stack_ptr_q;
  assign stack_top = jump_stack[stack_ptr_q - 4'h1];
  // ----------------------------------------------------------------
  // internal bus source select and external capture
  // ----------------------------------------------------------------
  always_comb begin
    unique case (src) // [RULE24]
      SRC_ALU: internal_data_bus = alu_y;
      SRC_LIT16: internal_data_bus = literal_q;
      SRC_LIT8: internal_data_bus = {8'h00, literal8};
      SRC_SCRATCH: internal_data_bus = scratch_ram_out;
      SRC_EXT: internal_data_bus = ext_bus_in;
      SRC_STACK: internal_data_bus = stack_top;
      default: internal_data_bus = RESET_WORD;
    endcase
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_bus_out <= RESET_WORD;
      ext_bus_strobe <= 1'b0;
    end else begin
      ext_bus_strobe <= micro_end && (dst == DST_EXT);
      if (micro_end && (dst == DST_EXT)) begin
        ext_bus_out <= internal_data_bus; // [RULE24]
      end
    end
  end
  // ----------------------------------------------------------------
  // level orders
  // ----------------------------------------------------------------
  wire [6:0] lvl_idx = cw[LVL_IDX_LSB +: 7];
  wire lvl_value = cw[LVL_VAL_BIT];
  wire lvl_write = micro_mid && (exec_fmt == FMT_LEVEL); // [RULE21]
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      level_orders <= '0; // [RULE22]
    end else if (lvl_write) begin
      level_orders[lvl_idx] <= lvl_value; // [RULE22]
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_literal_load;
    @(posedge clk_sys) disable iff (!reset_n) micro_end |=> literal_q == $past(control_store[47:32]);
  endproperty
  a_literal_load: assert property (p_literal_load) else $error("literal not captured"); // [RULE1]
  property p_lit_drive;
    @(posedge clk_sys) disable iff (!reset_n)
      micro_end ##1 literal_drive_enable |-> alu_input_bus == $past(control_store[LIT_LSB +: 16]);
  endproperty
  a_lit_drive: assert property (p_lit_drive) else $error("literal not on alu input"); // [RULE2]
  property p_count_up;
    @(posedge clk_sys) disable iff (!reset_n)
      micro_end && order_up && !scratch_addr_load |=> ram_address_counter_q == $past(ram_address_counter_q) + 12'h001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step up"); // [RULE4]
  property p_count_hold;
    @(posedge clk_sys) disable iff (!reset_n) !micro_end |=> $stable(ram_address_counter_q);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved off the tick"); // [RULE4]
  property p_addr_load;
    @(posedge clk_sys) disable iff (!reset_n)
      micro_end && scratch_addr_load |=> ram_address_counter_q == $past(internal_data_bus[11:0]);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("counter load missed"); // [RULE5]
  property p_format_jump;
    @(posedge clk_sys) disable iff (!reset_n) control_store[2:0] == 3'h6 |-> branch_take;
  endproperty
  a_format_jump: assert property (p_format_jump) else $error("format six did not branch"); // [RULE17]
  property p_format_none;
    @(posedge clk_sys) disable iff (!reset_n) control_store[2:0] == 3'h7 |-> !branch_take;
  endproperty
  a_format_none: assert property (p_format_none) else $error("format seven branched"); // [RULE17]
  sequence s_pulse_low;
    !pulse_orders_n.grp_a[PO_COUNT_UP] [*8];
  endsequence
  property p_pulse_width;
    @(posedge clk_sys) disable iff (!reset_n) micro_mid && order_up ##1 1'b1 |-> s_pulse_low ##1 1'b1;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse order too short"); // [RULE19]
  property p_stack_reset;
    @(posedge clk_sys) disable iff (!reset_n) micro_end && order_stack_reset |=> stack_ptr_q == 4'h0;
  endproperty
  a_stack_reset: assert property (p_stack_reset) else $error("stack counter not cleared"); // [RULE13]
  property p_level_set;
    @(posedge clk_sys) disable iff (!reset_n) lvl_write |=> level_orders[$past(lvl_idx)] == $past(lvl_value);
  endproperty
  a_level_set: assert property (p_level_set) else $error("level order not updated"); // [RULE22]
endmodule : microengine_field_decode_datapath

// ==== core/microengine_pkg.sv ====
// shared field positions, codes and timing for the microengine datapath
package microengine_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int MICROCYCLE_NS = 150;
  localparam int PULSE_NS = 75;
  localparam int MICRO_CLKS = MICROCYCLE_NS / CLK_PERIOD_NS;
  localparam int PULSE_CLKS = PULSE_NS / CLK_PERIOD_NS;
  localparam logic [4:0] PH_LAST = 5'(MICRO_CLKS - 1);
  localparam logic [4:0] PH_MID = 5'(MICRO_CLKS - PULSE_CLKS);
  // microword field positions
  localparam int FMT_LSB = 0;
  localparam int TIDX_MSB_BIT = 3;
  localparam int ALU_A_LSB = 4;
  localparam int ALU_B_LSB = 8;
  localparam int ALU_SRC_LSB = 13;
  localparam int ALU_FN_LSB = 17;
  localparam int ALU_DST_LSB = 21;
  localparam int SWAP_BIT = 16;
  localparam int ADDR_SEL_BIT = 20;
  localparam int CARRY_BIT = 3;
  localparam int BUS_DST_LSB = 24;
  localparam int TEST_EN_LSB = 24;
  localparam int TEST_IDX_LSB = 27;
  localparam int BUS_SRC_LSB = 28;
  localparam int POLARITY_BIT = 31;
  localparam int LIT_LSB = 32;
  localparam int LIT8_HI_LSB = 36;
  localparam int LIT8_LO_LSB = 40;
  localparam int GRP_EN_LSB = 36;
  localparam int PO_DEC_LSB = 40;
  localparam int LVL_VAL_BIT = 36;
  localparam int LVL_IDX_LSB = 37;
  localparam int SP_DIRECT_LSB = 36;
  // pulse order codes within group a
  localparam logic [3:0] PO_COUNT_UP = 4'h1;
  localparam logic [3:0] PO_COUNT_DOWN = 4'h2;
  localparam logic [3:0] PO_STACK_RESET = 4'h3;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  typedef enum logic [2:0] {
    FMT_FULL0 = 3'b000, FMT_LEVEL = 3'b001, FMT_MINI2 = 3'b010, FMT_MINI3 = 3'b011,
    FMT_FULL4 = 3'b100, FMT_NOTEST = 3'b101, FMT_JUMP = 3'b110, FMT_NONE = 3'b111
  } format_e;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000, SRC_ALU = 3'b001, SRC_LIT16 = 3'b010, SRC_LIT8 = 3'b011,
    SRC_SCRATCH = 3'b100, SRC_EXT = 3'b101, SRC_STACK = 3'b110, SRC_RSVD = 3'b111
  } bus_src_e;
  typedef enum logic [2:0] {
    DST_NONE = 3'b000, DST_SCRATCH = 3'b001, DST_ADDR = 3'b010, DST_EXT = 3'b011,
    DST_STACK = 3'b100, DST_R5 = 3'b101, DST_R6 = 3'b110, DST_R7 = 3'b111
  } bus_dst_e;
  typedef struct packed {
    logic [15:0] grp_d;
    logic [15:0] grp_c;
    logic [15:0] grp_b;
    logic [15:0] grp_a;
  } pulse_orders_s;
endpackage : microengine_pkg

// ==== core/scratch_pad_ram.sv ====
// scratch pad word store with straight or byte-exchanged read path
`timescale 1ns/1ps
module scratch_pad_ram #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 16
) (
  input wire logic clk_sys,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic we,
  input wire logic swap,
  output logic [DATA_W-1:0] rdata
);
  initial begin
    if (DATA_W != 16) $error("scratch pad must be a halfword wide");
  end
  logic [DATA_W-1:0] mem [2**ADDR_W];
  wire [DATA_W-1:0] raw = mem[addr];
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
  // the read port stays on; swapping only reroutes the bytes
  assign rdata = swap ? {raw[7:0], raw[15:8]} : raw;
endmodule : scratch_pad_ram

// ==== verification/control_store_model.sv ====
// control store and sequencer stand-in that presents one microword per microcycle
`timescale 1ns/1ps
module control_store_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic phase_three_clock,
  input wire logic [47:0] next_word,
  output logic [47:0] control_store
);
  // ----------------------------------------
  // fetch stage
  // ----------------------------------------
  // the word only moves on the end-of-cycle edge, so the fetch-stage test
  // sees it for the whole microcycle before the word register takes it over
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      control_store <= 48'h0;
    end else if (phase_three_clock) begin
      control_store <= next_word;
    end
  end
endmodule : control_store_model

// ==== verification/microengine_field_decode_datapath_test.sv ====
// self-checking bench for the microengine field decode datapath
`timescale 1ns/1ps
module microengine_field_decode_datapath_test;
  import microengine_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [47:0] next_word = 48'h0;
  logic [47:0] control_store;
  logic [31:0] test_bank_a = 32'h0, test_bank_b = 32'h0, test_bank_c = 32'h0;
  logic [15:0] ext_bus_in = 16'h0;
  logic branch_take, phase_three_clock, ext_bus_strobe;
  logic [7:0] wcs_addr;
  logic [15:0] internal_data_bus, ext_bus_out, stack_top;
  logic [3:0] stack_ptr;
  logic [127:0] level_orders;
  pulse_orders_s pulse_orders_n;
  logic [47:0] w;
  logic [47:0] nop;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 93;
  always #4 clk_sys = ~clk_sys;
  control_store_model control_store_model_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .phase_three_clock(phase_three_clock), .next_word(next_word), .control_store(control_store));
  microengine_field_decode_datapath microengine_field_decode_datapath_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .control_store(control_store), .test_bank_a(test_bank_a), .test_bank_b(test_bank_b),
    .test_bank_c(test_bank_c), .ext_bus_in(ext_bus_in), .branch_take(branch_take),
    .phase_three_clock(phase_three_clock), .wcs_addr(wcs_addr), .internal_data_bus(internal_data_bus),
    .ext_bus_out(ext_bus_out), .ext_bus_strobe(ext_bus_strobe), .stack_top(stack_top),
    .stack_ptr(stack_ptr), .level_orders(level_orders), .pulse_orders_n(pulse_orders_n));
  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic logic [47:0] mk(input logic [2:0] f, input logic [2:0] s, input logic [2:0] d,
                                     input logic [15:0] l);
    return {l, 1'b0, s, 1'b0, d, 21'h0, f};
  endfunction : mk
  function automatic logic exp_branch(input logic [47:0] x, input logic [31:0] a, input logic [31:0] b,
                                      input logic [31:0] c);
    logic [4:0] i;
    logic [2:0] en;
    i = (x[2:0] == 3'h0 || x[2:0] == 3'h4) ? {x[3], x[30:27]} : {x[27], 4'h0};
    en = (x[2:0] > 3'h4) ? 3'h0 : x[26:24];
    return (x[2:0] == 3'h6) | (en[0] & (a[i] ^ x[31])) | (en[1] & (b[i] ^ x[31])) | (en[2] & (c[i] ^ x[31]));
  endfunction : exp_branch
  // hands the next word to the partner and returns just after it is fetched
  task automatic step(input logic [47:0] x);
    int n;
    n = 0;
    @(posedge clk_sys);
    next_word <= x;
    test_bank_a <= $random(seed);
    test_bank_b <= $random(seed);
    test_bank_c <= $random(seed);
    do begin
      @(negedge clk_sys);
      n++;
      if (n > 40) begin
        bad_count++;
        test_done();
      end
    end while (phase_three_clock !== 1'b1);
    @(negedge clk_sys);
  endtask : step
  // walks one executing microcycle from phase 0
  task automatic chk_po(input logic [15:0] act, input logic [3:0] grp);
    for (int ph = 0; ph < 18; ph++) begin
      chk("po_a", (ph >= 9 && grp[0]) ? act : 16'hffff, pulse_orders_n.grp_a);
      chk("po_b", (ph >= 9 && grp[1]) ? act : 16'hffff, pulse_orders_n.grp_b);
      chk("po_c", (ph >= 9 && grp[2]) ? act : 16'hffff, pulse_orders_n.grp_c);
      chk("po_d", (ph >= 9 && grp[3]) ? act : 16'hffff, pulse_orders_n.grp_d);
      @(negedge clk_sys);
    end
  endtask : chk_po
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nop = mk(3'h5, 3'h0, 3'h0, 16'h0);
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    chk("level_rst", 16'h0, {15'h0, |level_orders});
    for (int k = 0; k < 48; k++) begin
      w = {16'($random(seed)), 32'($random(seed))};
      w[2:0] = 3'(k);
      step(w);
      chk("branch", {15'h0, exp_branch(w, test_bank_a, test_bank_b, test_bank_c)}, {15'h0, branch_take});
    end
    // reset in mid-run after random traffic has moved the stack and latches
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    chk("stack_rst", 16'h0, {12'h0, stack_ptr});
    chk("level_rst", 16'h0, {15'h0, |level_orders});
    step(mk(3'h5, 3'h2, 3'h2, 16'h1200));
    step(nop);
    chk("bus_lit16", 16'h1200, internal_data_bus);
    step(mk(3'h0, 3'h0, 3'h0, 16'h0100));
    chk("wcs_load", 16'h0, {8'h0, wcs_addr});
    step(nop);
    chk_po(~16'h0002, 4'h1);
    step(mk(3'h2, 3'h0, 3'h0, 16'h0210));
    chk("wcs_up", 16'h1, {8'h0, wcs_addr});
    step(mk(3'h2, 3'h0, 3'h0, 16'h0210));
    step(nop);
    step(nop);
    chk("wcs_down", 16'h00ff, {8'h0, wcs_addr});
    step(nop);
    chk("wcs_hold", 16'h00ff, {8'h0, wcs_addr});
    step(mk(3'h2, 3'h0, 3'h0, 16'h05f0));
    step(nop);
    chk_po(~16'h0020, 4'hf);
    step(mk(3'h5, 3'h2, 3'h1, 16'hab37) | 48'h100000);
    step(mk(3'h5, 3'h4, 3'h0, 16'hab30) | 48'h100000);
    step(mk(3'h5, 3'h4, 3'h0, 16'hab30) | 48'h110000);
    chk("scratch_rd", 16'hab37, internal_data_bus);
    step(mk(3'h5, 3'h3, 3'h0, 16'h0690));
    chk("scratch_swap", 16'h37ab, internal_data_bus);
    step(nop);
    chk("bus_lit8", 16'h0096, internal_data_bus);
    @(posedge clk_sys);
    ext_bus_in <= 16'hc3e1;
    step(mk(3'h5, 3'h5, 3'h4, 16'h0));
    step(mk(3'h5, 3'h5, 3'h3, 16'h0));
    chk("bus_ext", 16'hc3e1, internal_data_bus);
    step(mk(3'h2, 3'h0, 3'h0, 16'h0310));
    chk("stack_top", 16'hc3e1, stack_top);
    chk("stack_push", 16'h1, {12'h0, stack_ptr});
    step(nop);
    chk("ext_out", 16'hc3e1, ext_bus_out);
    chk("ext_strobe", 16'h1, {15'h0, ext_bus_strobe});
    step(nop);
    chk("stack_clear", 16'h0, {12'h0, stack_ptr});
    chk("ext_strobe_end", 16'h0, {15'h0, ext_bus_strobe});
    step(mk(3'h1, 3'h0, 3'h0, 16'h0ff0));
    step(nop);
    repeat (7) @(negedge clk_sys);
    chk("level_early", 16'h0, {15'h0, level_orders[127]});
    repeat (3) @(negedge clk_sys);
    chk("level_set", 16'h1, {15'h0, level_orders[127]});
    chk("level_other", 16'h0, {15'h0, level_orders[126]});
    step(mk(3'h1, 3'h0, 3'h0, 16'h0fe0));
    step(nop);
    step(nop);
    chk("level_clr", 16'h0, {15'h0, level_orders[127]});
    // d input plus carry in, written to register 5, then read back through port a
    @(posedge clk_sys);
    ext_bus_in <= 16'h7fff;
    step(mk(3'h5, 3'h1, 3'h0, 16'h0) | 48'h60e508);
    step(mk(3'h5, 3'h1, 3'h0, 16'h0) | 48'h208050);
    chk("alu_carry", 16'h8000, internal_data_bus);
    step(nop);
    chk("alu_regfile", 16'h8000, internal_data_bus);
    test_done();
  end
endmodule : microengine_field_decode_datapath_test
